// file: logic/pwbp_pkg.sv
// Purpose: shared constants and carriers for the page window and bus priority block
// Assumes: one 125 MHz clock, core and debug master on the same clock
// Notes:   stack grows downward, 16-bit values stored as one wide access
package pwbp_pkg;

  localparam int          PWBP_CLK_PERIOD_NS = 8;
  localparam int          PWBP_BDM_WAIT_MAX  = 128;
  localparam logic [7:0]  PWBP_WAIT_LIMIT    = PWBP_BDM_WAIT_MAX[7:0];
  localparam logic [7:0]  PWBP_WAIT_SAT      = 8'hFF;
  localparam int          PWBP_PAGE_BITS     = 8;
  localparam int          PWBP_WIN_BITS      = 14;
  localparam int          PWBP_PHYS_BITS     = PWBP_PAGE_BITS + PWBP_WIN_BITS;
  localparam logic [1:0]  PWBP_WIN_SEL       = 2'h2;
  localparam logic [7:0]  PWBP_PAGE_RESET    = 8'h00;
  localparam logic [15:0] PWBP_STEP_WORD     = 16'h0002;
  localparam logic [15:0] PWBP_STEP_BYTE     = 16'h0001;

  typedef enum logic [1:0] {
    PWBP_ARB_IDLE = 2'b00,
    PWBP_ARB_CORE = 2'b01,
    PWBP_ARB_BDM  = 2'b10
  } pwbp_arb_type;

  typedef enum logic [3:0] {
    PWBP_SEQ_IDLE      = 4'b0000,
    PWBP_SEQ_PTR_PAGE  = 4'b0001,
    PWBP_SEQ_PTR_ADDR  = 4'b0010,
    PWBP_SEQ_SWAP      = 4'b0011,
    PWBP_SEQ_PUSH_RET  = 4'b0100,
    PWBP_SEQ_PUSH_PAGE = 4'b0101,
    PWBP_SEQ_JUMP      = 4'b0110,
    PWBP_SEQ_POP_PAGE  = 4'b0111,
    PWBP_SEQ_POP_RET   = 4'b1000
  } pwbp_seq_type;

  typedef struct packed {
    logic        start_call;
    logic        start_rtc;
    logic        indirect;
    logic [7:0]  page;
    logic [15:0] target;
    logic [15:0] ret_pc;
    logic [15:0] sp;
    logic [15:0] ptr;
  } pwbp_cmd_type;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic        wide;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pwbp_mem_type;

  typedef struct packed {
    pwbp_arb_type arb;
    logic [7:0]   bdm_wait;
    logic         core_gnt;
    logic         bdm_gnt;
    logic         core_stall;
    pwbp_seq_type seq;
    logic [7:0]   page;
    logic [7:0]   saved_page;
    logic [7:0]   new_page;
    logic [15:0]  target;
    logic [15:0]  ret_pc;
    logic [15:0]  sp;
    logic [15:0]  ptr;
    pwbp_mem_type mem;
    logic         irq_hold;
    logic         exec_start;
    logic [15:0]  exec_pc;
    logic [15:0]  exec_sp;
    logic [PWBP_PHYS_BITS-1:0] phys_addr;
    logic         phys_paged;
  } pwbp_state_type;

endpackage : pwbp_pkg

// file: logic/pwbp_top.sv
// Purpose: bus arbitration between core and debug master, plus paged call/return sequencing
// Assumes: all inputs come from logic on ref_clk; memory port answers with mem_ack
// Notes:   the block raises no interrupt request; its irq_hold output only masks interrupts during paged sequences
module pwbp_top (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 core_req,
  input  wire logic                 core_op_last,
  input  wire logic                 bdm_req,
  output logic                      core_gnt,
  output logic                      bdm_gnt,
  output logic                      core_stall,
  input  pwbp_pkg::pwbp_cmd_type    cmd,
  output pwbp_pkg::pwbp_mem_type    mem_req,
  input  wire logic                 mem_ack,
  input  wire logic [15:0]          mem_rdata,
  output logic                      irq_hold,
  output logic                      exec_start,
  output logic [15:0]               exec_pc,
  output logic [15:0]               exec_sp,
  output logic [7:0]                program_page_select,
  input  wire logic [15:0]          local_addr,
  output logic [pwbp_pkg::PWBP_PHYS_BITS-1:0] phys_addr,
  output logic                      phys_paged
);
  import pwbp_pkg::*;

  pwbp_state_type st_ff;
  pwbp_state_type nxt_st;
  logic           bdm_urgent;
  logic           mem_done;

  assign bdm_urgent = st_ff.bdm_wait > PWBP_WAIT_LIMIT;
  assign mem_done   = st_ff.mem.valid && mem_ack;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.exec_start = 1'b0;

    // waiting counter saturates so a long hold-off never wraps back to low priority
    if (!bdm_req || st_ff.bdm_gnt) begin
      nxt_st.bdm_wait = 8'h00;
    end else if (st_ff.bdm_wait != PWBP_WAIT_SAT) begin
      nxt_st.bdm_wait = st_ff.bdm_wait + 8'h01;
    end

    unique case (st_ff.arb)
      PWBP_ARB_IDLE: begin
        if (bdm_req && (bdm_urgent || !core_req)) begin
          nxt_st.arb = PWBP_ARB_BDM;
        end else if (core_req) begin
          nxt_st.arb = PWBP_ARB_CORE;
        end
      end
      PWBP_ARB_CORE: begin
        if (!core_req) begin
          nxt_st.arb = PWBP_ARB_IDLE;
        end else if (core_op_last && bdm_req && bdm_urgent) begin
          nxt_st.arb = PWBP_ARB_BDM;
        end
      end
      PWBP_ARB_BDM: begin
        if (!bdm_req) begin
          nxt_st.arb = PWBP_ARB_IDLE;
        end
      end
      default: nxt_st.arb = PWBP_ARB_IDLE;
    endcase
    // grants decode from a single state, so two owners cannot coexist
    nxt_st.core_gnt   = (nxt_st.arb == PWBP_ARB_CORE);
    nxt_st.bdm_gnt    = (nxt_st.arb == PWBP_ARB_BDM);
    nxt_st.core_stall = core_req && (nxt_st.arb == PWBP_ARB_BDM);

    if (mem_done) begin
      nxt_st.mem.valid = 1'b0;
    end
    unique case (st_ff.seq)
      PWBP_SEQ_IDLE: begin
        nxt_st.ret_pc = cmd.ret_pc;
        nxt_st.sp     = cmd.sp;
        nxt_st.ptr    = cmd.ptr;
        if (cmd.start_call) begin
          nxt_st.target = cmd.target;
          if (cmd.indirect) begin
            nxt_st.seq = PWBP_SEQ_PTR_PAGE;
            nxt_st.mem = '{valid: 1'b1, we: 1'b0, wide: 1'b0, addr: cmd.ptr, wdata: 16'h0000};
          end else begin
            nxt_st.new_page = cmd.page;
            nxt_st.seq      = PWBP_SEQ_SWAP;
          end
        end else if (cmd.start_rtc) begin
          nxt_st.seq = PWBP_SEQ_POP_PAGE;
          nxt_st.mem = '{valid: 1'b1, we: 1'b0, wide: 1'b0, addr: cmd.sp, wdata: 16'h0000};
        end
      end
      PWBP_SEQ_PTR_PAGE: begin
        if (mem_done) begin
          nxt_st.new_page = mem_rdata[7:0];
          nxt_st.seq      = PWBP_SEQ_PTR_ADDR;
          nxt_st.mem      = '{valid: 1'b1, we: 1'b0, wide: 1'b1, addr: st_ff.ptr + PWBP_STEP_BYTE,
                              wdata: 16'h0000};
        end
      end
      PWBP_SEQ_PTR_ADDR: begin
        if (mem_done) begin
          nxt_st.target = mem_rdata;
          nxt_st.seq    = PWBP_SEQ_SWAP;
        end
      end
      PWBP_SEQ_SWAP: begin
        nxt_st.saved_page = st_ff.page;
        nxt_st.page       = st_ff.new_page;
        nxt_st.sp         = st_ff.sp - PWBP_STEP_WORD;
        nxt_st.mem        = '{valid: 1'b1, we: 1'b1, wide: 1'b1, addr: st_ff.sp - PWBP_STEP_WORD,
                              wdata: st_ff.ret_pc};
        nxt_st.seq        = PWBP_SEQ_PUSH_RET;
      end
      PWBP_SEQ_PUSH_RET: begin
        if (mem_done) begin
          nxt_st.sp  = st_ff.sp - PWBP_STEP_BYTE;
          nxt_st.mem = '{valid: 1'b1, we: 1'b1, wide: 1'b0, addr: st_ff.sp - PWBP_STEP_BYTE,
                         wdata: {8'h00, st_ff.saved_page}};
          nxt_st.seq = PWBP_SEQ_PUSH_PAGE;
        end
      end
      PWBP_SEQ_PUSH_PAGE: begin
        if (mem_done) begin
          nxt_st.seq = PWBP_SEQ_JUMP;
        end
      end
      PWBP_SEQ_JUMP: begin
        nxt_st.exec_start = 1'b1;
        nxt_st.exec_pc    = st_ff.target;
        nxt_st.exec_sp    = st_ff.sp;
        nxt_st.seq        = PWBP_SEQ_IDLE;
      end
      PWBP_SEQ_POP_PAGE: begin
        if (mem_done) begin
          nxt_st.page = mem_rdata[7:0];
          nxt_st.sp   = st_ff.sp + PWBP_STEP_BYTE;
          nxt_st.mem  = '{valid: 1'b1, we: 1'b0, wide: 1'b1, addr: st_ff.sp + PWBP_STEP_BYTE,
                          wdata: 16'h0000};
          nxt_st.seq  = PWBP_SEQ_POP_RET;
        end
      end
      PWBP_SEQ_POP_RET: begin
        if (mem_done) begin
          nxt_st.target = mem_rdata;
          nxt_st.sp     = st_ff.sp + PWBP_STEP_WORD;
          nxt_st.seq    = PWBP_SEQ_JUMP;
        end
      end
      default: nxt_st.seq = PWBP_SEQ_IDLE;
    endcase
    // hold interrupts from the accepting edge until the jump is issued
    nxt_st.irq_hold = (nxt_st.seq != PWBP_SEQ_IDLE);

    nxt_st.phys_paged = (local_addr[15:14] == PWBP_WIN_SEL);
    nxt_st.phys_addr  = nxt_st.phys_paged ? {st_ff.page, local_addr[PWBP_WIN_BITS-1:0]}
                                          : {6'h00, local_addr};
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_ff      <= '0;
      st_ff.arb  <= PWBP_ARB_IDLE;
      st_ff.seq  <= PWBP_SEQ_IDLE;
      st_ff.page <= PWBP_PAGE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // no interrupt request port exists at all
  assign core_gnt            = st_ff.core_gnt;
  assign bdm_gnt             = st_ff.bdm_gnt;
  assign core_stall          = st_ff.core_stall;
  assign mem_req             = st_ff.mem;
  assign irq_hold            = st_ff.irq_hold;
  assign exec_start          = st_ff.exec_start;
  assign exec_pc             = st_ff.exec_pc;
  assign exec_sp             = st_ff.exec_sp;
  assign program_page_select = st_ff.page;
  assign phys_addr           = st_ff.phys_addr;
  assign phys_paged          = st_ff.phys_paged;

  sequence s_call_accept;
    st_ff.seq == PWBP_SEQ_SWAP;
  endsequence

  sequence s_ret_pushed;
    st_ff.seq == PWBP_SEQ_PUSH_RET && mem_done && st_ff.mem.wide && st_ff.mem.we;
  endsequence

  a_grant_one_owner: assert property (@(posedge ref_clk) disable iff (rst)
    !(core_gnt && bdm_gnt))
    else $error("both masters granted");

  a_core_wins_tie: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.arb == PWBP_ARB_IDLE && core_req && bdm_req && !bdm_urgent) |=> core_gnt && !bdm_gnt)
    else $error("core lost a normal contention");

  a_bdm_takes_over: assert property (@(posedge ref_clk) disable iff (rst)
    (core_gnt && core_req && core_op_last && bdm_req && st_ff.bdm_wait > PWBP_WAIT_LIMIT) |=> bdm_gnt && core_stall)
    else $error("debug master not promoted after long wait");

  a_core_op_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (core_gnt && core_req && !core_op_last) |=> core_gnt)
    else $error("core cut off mid operation");

  a_call_page_swap: assert property (@(posedge ref_clk) disable iff (rst)
    s_call_accept |=> program_page_select == $past(st_ff.new_page) && st_ff.saved_page == $past(st_ff.page))
    else $error("page not swapped on call");

  a_call_push_order: assert property (@(posedge ref_clk) disable iff (rst)
    s_ret_pushed |=> mem_req.valid && mem_req.we && !mem_req.wide && mem_req.wdata[7:0] == st_ff.saved_page)
    else $error("saved page not pushed after return address");

  a_seq_irq_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.seq != PWBP_SEQ_IDLE) |-> irq_hold)
    else $error("interrupts open during paged sequence");

  a_direct_page: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.seq == PWBP_SEQ_IDLE && cmd.start_call && !cmd.indirect) |=> ##1 program_page_select == $past(cmd.page, 2))
    else $error("immediate page not used");

  a_rtc_page_pop: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.seq == PWBP_SEQ_POP_PAGE && mem_done) |=> program_page_select == $past(mem_rdata[7:0]) && mem_req.wide)
    else $error("return did not restore page first");

  a_jump_start: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.seq == PWBP_SEQ_JUMP) |=> exec_start && exec_pc == $past(st_ff.target))
    else $error("execution not started at target");

  a_window_map: assert property (@(posedge ref_clk) disable iff (rst)
    (local_addr[15:14] == 2'h2) |=> phys_paged && phys_addr[13:0] == $past(local_addr[13:0]))
    else $error("window address not mapped");

  // stepwise checks of the debug hold-off and of the paged sequences
  sequence s_ptr_page_done;
    st_ff.seq == PWBP_SEQ_PTR_PAGE && mem_done;
  endsequence

  sequence s_pop_ret_done;
    st_ff.seq == PWBP_SEQ_POP_RET && mem_done;
  endsequence

  sequence s_seq_start;
    st_ff.seq == PWBP_SEQ_IDLE && (cmd.start_call || cmd.start_rtc);
  endsequence

  a_wait_counts: assert property (@(posedge ref_clk) disable iff (rst)
    (bdm_req && !bdm_gnt && st_ff.bdm_wait != PWBP_WAIT_SAT) |=> st_ff.bdm_wait == $past(st_ff.bdm_wait) + 8'h01)
    else $error("debug wait count not advancing");

  a_core_not_early: assert property (@(posedge ref_clk) disable iff (rst)
    (core_gnt && core_req && st_ff.bdm_wait <= PWBP_WAIT_LIMIT) |=> core_gnt && !bdm_gnt)
    else $error("debug master promoted too early");

  a_stall_for_bdm: assert property (@(posedge ref_clk) disable iff (rst)
    core_stall |-> bdm_gnt && !core_gnt)
    else $error("core stalled without debug ownership");

  a_call_irq_start: assert property (@(posedge ref_clk) disable iff (rst)
    s_seq_start |=> irq_hold)
    else $error("interrupts open at sequence start");

  a_push_ret_word: assert property (@(posedge ref_clk) disable iff (rst)
    s_call_accept |=> mem_req.valid && mem_req.we && mem_req.wide && mem_req.wdata == $past(st_ff.ret_pc)
      && mem_req.addr == $past(st_ff.sp) - PWBP_STEP_WORD)
    else $error("return address not pushed as one word");

  a_ptr_second_read: assert property (@(posedge ref_clk) disable iff (rst)
    s_ptr_page_done |=> st_ff.new_page == $past(mem_rdata[7:0]) && mem_req.valid && mem_req.wide && !mem_req.we)
    else $error("pointer reads out of step");

  a_rtc_resume: assert property (@(posedge ref_clk) disable iff (rst)
    s_pop_ret_done |=> ##1 exec_start && exec_pc == $past(mem_rdata, 2))
    else $error("return did not resume at popped address");

  a_exec_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    exec_start |=> !exec_start)
    else $error("execution start held too long");

  a_page_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (st_ff.seq == PWBP_SEQ_IDLE && !cmd.start_call && !cmd.start_rtc) |=> $stable(program_page_select))
    else $error("page changed outside a paged sequence");

endmodule : pwbp_top

// file: verification/pwbp_mem_model.sv
// Purpose: memory model answering the block's memory port
// Assumes: one request at a time, held until acknowledged
// Notes:   read data flips every idle cycle so a stale value never matches by luck
module pwbp_mem_model (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              slow,
  input  pwbp_pkg::pwbp_mem_type mem_req,
  output logic                   mem_ack,
  output logic [15:0]            mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwbp_pkg::*;
  logic [15:0] mem [logic [15:0]];
  logic [15:0] wlog [$];
  logic [1:0]  dly;

  // slow mode answers after three extra waits to stretch every access
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 16'h0000;
      dly       <= 2'h0;
    end else if (mem_req.valid && !mem_ack && (!slow || dly == 2'h3)) begin
      mem_ack <= 1'b1;
      dly     <= 2'h0;
      if (mem_req.we) begin
        mem[mem_req.addr] = mem_req.wdata;
        wlog.push_back(mem_req.addr);
      end else begin
        mem_rdata <= mem.exists(mem_req.addr) ? mem[mem_req.addr] : 16'h0000;
      end
    end else begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req.valid && !mem_ack) begin
        dly <= dly + 2'h1;
      end
    end
  end
endmodule : pwbp_mem_model

// file: verification/tb_pwbp_top.sv
// Purpose: self-checking bench for arbitration and paged call/return
// Assumes: memory model answers the memory port, bench plays core and debug master
// Notes:   pointer contents are preloaded into the model directly; stack contents come from the block's own pushes
module tb_pwbp_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pwbp_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, core_req = 1'b0, core_op_last = 1'b0, bdm_req = 1'b0;
  logic core_gnt, bdm_gnt, core_stall, mem_ack, irq_hold, exec_start, phys_paged, slow = 1'b0;
  logic [15:0] mem_rdata, exec_pc, exec_sp, local_addr = 16'h0000;
  logic [7:0]  program_page_select;
  logic [PWBP_PHYS_BITS-1:0] phys_addr;
  pwbp_cmd_type cmd = '0;
  pwbp_mem_type mem_req;
  int bad_count = 0, n_checks = 0, cycles = 0;

  pwbp_top i_pwbp_top (.ref_clk(ref_clk), .rst(rst), .core_req(core_req), .core_op_last(core_op_last),
    .bdm_req(bdm_req), .core_gnt(core_gnt), .bdm_gnt(bdm_gnt), .core_stall(core_stall), .cmd(cmd),
    .mem_req(mem_req), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq_hold(irq_hold),
    .exec_start(exec_start), .exec_pc(exec_pc), .exec_sp(exec_sp), .program_page_select(program_page_select),
    .local_addr(local_addr), .phys_addr(phys_addr), .phys_paged(phys_paged));
  pwbp_mem_model i_pwbp_mem_model (.ref_clk(ref_clk), .rst(rst), .slow(slow), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #4 ref_clk = ~ref_clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize

  // the monitor also cuts a hang short; it looks on the falling edge, away from the launching edge
  always @(negedge ref_clk) begin
    cycles++;
    if (!rst) check("one owner", {31'h0, core_gnt & bdm_gnt}, 32'h0);
    if (cycles == 6000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic start(input pwbp_cmd_type c);
    @(posedge ref_clk);
    cmd <= c;
    @(posedge ref_clk);
    cmd.start_call <= 1'b0;
    cmd.start_rtc  <= 1'b0;
  endtask : start

  task automatic wait_exec();
    int n;
    for (n = 0; n < 80; n++) begin
      @(posedge ref_clk);
      #1;
      if (exec_start === 1'b1) break;
    end
    check("exec start", {31'h0, exec_start}, 32'h1);
  endtask : wait_exec

  task automatic t_reset();
    check("reset gnt", {core_gnt, bdm_gnt, core_stall, irq_hold, exec_start}, 32'h0);
    check("reset page", program_page_select, 32'h0);
  endtask : t_reset

  task automatic t_arbitrate();
    @(posedge ref_clk);
    core_req <= 1'b1;
    bdm_req  <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check("core first", {core_gnt, bdm_gnt}, 32'h2);
    // operation ends while the wait count is exactly 128: not above it, so the core stays
    repeat (125) @(posedge ref_clk);
    core_op_last <= 1'b1;
    @(posedge ref_clk);
    core_op_last <= 1'b0;
    #1;
    check("wait 128 holds", {core_gnt, bdm_gnt}, 32'h2);
    repeat (10) @(posedge ref_clk);
    #1;
    check("core keeps op", {core_gnt, bdm_gnt}, 32'h2);
    @(posedge ref_clk);
    core_op_last <= 1'b1;
    @(posedge ref_clk);
    core_op_last <= 1'b0;
    #1;
    check("debug wins", {core_gnt, bdm_gnt, core_stall}, 32'h3);
    @(posedge ref_clk);
    bdm_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("core back", {core_gnt, bdm_gnt, core_stall}, 32'h4);
    @(posedge ref_clk);
    core_req <= 1'b0;
  endtask : t_arbitrate

  task automatic t_indirect();
    i_pwbp_mem_model.mem[16'h0300] = 16'h0077;
    i_pwbp_mem_model.mem[16'h0301] = 16'h9000;
    start('{start_call: 1'b1, indirect: 1'b1, page: 8'h11, target: 16'h0000, ret_pc: 16'h0500,
      sp: 16'h2000, ptr: 16'h0300, default: '0});
    wait_exec();
    check("ind page", program_page_select, 32'h77);
    check("ind pc", exec_pc, 32'h9000);
  endtask : t_indirect

  task automatic t_direct();
    int n;
    slow = 1'b1;
    i_pwbp_mem_model.wlog.delete();
    start('{start_call: 1'b1, page: 8'h5A, target: 16'h8100, ret_pc: 16'h1234, sp: 16'h1000, default: '0});
    for (n = 0; n < 10 && mem_req.valid !== 1'b1; n++) @(posedge ref_clk);
    #1;
    check("new page", program_page_select, 32'h5A);
    check("inhibit", {31'h0, irq_hold}, 32'h1);
    @(posedge ref_clk);
    cmd.start_rtc <= 1'b1;
    @(posedge ref_clk);
    cmd.start_rtc <= 1'b0;
    wait_exec();
    check("call pc", exec_pc, 32'h8100);
    check("call sp", exec_sp, 32'h0FFD);
    check("ret word", i_pwbp_mem_model.mem[16'h0FFE], 32'h1234);
    check("page byte", i_pwbp_mem_model.mem[16'h0FFD][7:0], 32'h77);
    check("push order", {i_pwbp_mem_model.wlog[0], i_pwbp_mem_model.wlog[1]}, 32'h0FFE0FFD);
    slow = 1'b0;
  endtask : t_direct

  task automatic t_window();
    @(posedge ref_clk);
    local_addr <= 16'h8123;
    repeat (2) @(posedge ref_clk);
    #1;
    check("window map", {phys_paged, phys_addr}, {9'h0, 1'b1, 8'h5A, 14'h0123});
    @(posedge ref_clk);
    local_addr <= 16'h4000;
    repeat (2) @(posedge ref_clk);
    #1;
    check("flat map", {phys_paged, phys_addr}, {9'h0, 1'b0, 22'h004000});
  endtask : t_window

  task automatic t_return();
    start('{start_rtc: 1'b1, sp: 16'h0FFD, default: '0});
    wait_exec();
    check("rtc page", program_page_select, 32'h77);
    check("rtc pc", exec_pc, 32'h1234);
    check("rtc sp", exec_sp, 32'h1000);
    check("idle after", {31'h0, irq_hold}, 32'h0);
  endtask : t_return

  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    t_reset();
    @(posedge ref_clk);
    rst <= 1'b0;
    t_arbitrate();
    t_indirect();
    t_direct();
    t_window();
    t_return();
    summarize();
  end
endmodule : tb_pwbp_top
